// *** rtl/sbrd_core.sv ***
// Execute stage for branches, returns, logic immediates and registers.
`timescale 1ns/1ps
`include "sbrd_cfg.svh"

module sbrd_core (
    input wire logic mclk,
    input wire logic rst,
    input wire sbrd_pkg::sbrd_exec_t ex,
    output logic [31:0] pc_out,
    output logic [31:0] status_out,
    output logic kill_fetch,
    output logic kill_decode,
    output sbrd_pkg::sbrd_wb_t wb
);
    import sbrd_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] ext_imm(input logic pv,
        input logic [15:0] hi, input logic [15:0] lo);
        ext_imm = pv ? {hi, lo} : {{16{lo[15]}}, lo};
    endfunction
    function automatic logic [31:0] gpr_read(input logic [31:0][31:0] f,
        input logic [4:0] i);
        gpr_read = (i == 5'h00) ? 32'h00000000 : f[i];
    endfunction
    function automatic logic cond_holds(input logic [2:0] c,
        input logic [31:0] v);
        logic neg;
        logic zero;
        neg = v[31];
        zero = (v == 32'h00000000);
        case (c)
            3'h0: cond_holds = zero;
            3'h1: cond_holds = !zero;
            3'h2: cond_holds = neg;
            3'h3: cond_holds = neg || zero;
            3'h4: cond_holds = !neg && !zero;
            default: cond_holds = !neg;
        endcase
    endfunction
    function automatic logic cond_sel_ok(input logic [4:0] s);
        cond_sel_ok = !s[3] && (s[2:0] <= `SBRD_COND_LAST);
    endfunction

    sbrd_state_t st;
    sbrd_state_t next_st;

    // ------------------------------------------------------------
    // Field split and operand read
    // ------------------------------------------------------------
    logic [5:0] op;
    logic [4:0] fa;
    logic [4:0] fb;
    logic [4:0] frb;
    logic [31:0] simm;
    logic [31:0] ra_val;
    logic [31:0] rb_val;

    assign op = ex.word[31:26];
    assign fa = ex.word[25:21];
    assign fb = ex.word[20:16];
    assign frb = ex.word[15:11];
    assign simm = ext_imm(st.pfx_valid, st.pfx_hi, ex.word[15:0]);
    assign ra_val = gpr_read(st.gpr, fb);
    assign rb_val = gpr_read(st.gpr, frb);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic take;
    logic delayed;
    logic link;
    logic brk;
    logic rti;
    logic rtb;
    logic is_mts;
    logic is_mfs;
    logic is_logic;
    logic is_pfx;
    logic [31:0] target;
    logic [31:0] logic_res;

    always_comb begin
        take = 1'b0;
        delayed = 1'b0;
        link = 1'b0;
        brk = 1'b0;
        rti = 1'b0;
        rtb = 1'b0;
        is_mts = 1'b0;
        is_mfs = 1'b0;
        is_logic = 1'b0;
        is_pfx = 1'b0;
        target = 32'h00000000;
        logic_res = 32'h00000000;
        if (ex.valid) begin
            case (op)
                `SBRD_OP_BCC_REG: begin
                    take = cond_sel_ok(fa) && cond_holds(fa[2:0], ra_val);
                    delayed = fa[4];
                    target = ex.pc + rb_val;
                end
                `SBRD_OP_BCC_IMM: begin
                    take = cond_sel_ok(fa) && cond_holds(fa[2:0], ra_val);
                    delayed = fa[4];
                    target = ex.pc + simm;
                end
                `SBRD_OP_JUMP_IMM: begin
                    delayed = fb[4];
                    case (fb)
                        `SBRD_SEL_REL_DELAYED, `SBRD_SEL_REL_LINK: begin
                            take = 1'b1;
                            link = (fb == `SBRD_SEL_REL_LINK);
                            target = ex.pc + simm;
                        end
                        `SBRD_SEL_ABS, `SBRD_SEL_ABS_DELAYED,
                        `SBRD_SEL_ABS_LINK: begin
                            take = 1'b1;
                            link = (fb == `SBRD_SEL_ABS_LINK);
                            target = simm;
                        end
                        `SBRD_SEL_BREAK: begin
                            take = 1'b1;
                            link = 1'b1;
                            brk = 1'b1;
                            target = simm;
                        end
                        default: take = 1'b0;
                    endcase
                end
                `SBRD_OP_RETURN: begin
                    target = ra_val + simm;
                    delayed = 1'b1;
                    take = (fa == `SBRD_SEL_RET_SUB) ||
                        (fa == `SBRD_SEL_RET_INT) ||
                        (fa == `SBRD_SEL_RET_BRK);
                    rti = (fa == `SBRD_SEL_RET_INT);
                    rtb = (fa == `SBRD_SEL_RET_BRK);
                end
                `SBRD_OP_OR_IMM: begin
                    is_logic = 1'b1;
                    logic_res = ra_val | simm;
                end
                `SBRD_OP_AND_IMM: begin
                    is_logic = 1'b1;
                    logic_res = ra_val & simm;
                end
                `SBRD_OP_XOR_IMM: begin
                    is_logic = 1'b1;
                    logic_res = ra_val ^ simm;
                end
                `SBRD_OP_ANDN_IMM: begin
                    is_logic = 1'b1;
                    logic_res = ra_val & ~simm;
                end
                `SBRD_OP_IMM_PREFIX: is_pfx = 1'b1;
                `SBRD_OP_SPECIAL: begin
                    is_mts = (ex.word[15:14] == `SBRD_SPC_MTS) &&
                        (ex.word[0] == `SBRD_STATUS_SPECIAL_INDEX);
                    is_mfs = (ex.word[15:14] == `SBRD_SPC_MFS);
                end
                default: take = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.wb.valid = 1'b0;
        next_st.kill_fetch = take;
        next_st.kill_decode = take && !delayed;
        next_st.program_counter = take ? target :
            st.program_counter + `SBRD_PC_STEP;
        // A pending status write lands first so that a break or return
        // in the following instruction still wins on its own flag.
        if (st.pend_valid) begin
            next_st.machine_status = st.pend_data;
        end
        next_st.pend_valid = is_mts;
        if (is_mts) begin
            next_st.pend_data = ra_val;
        end
        if (ex.valid) begin
            next_st.pfx_valid = is_pfx;
            if (is_pfx) begin
                next_st.pfx_hi = ex.word[15:0];
            end
        end
        if (brk) begin
            next_st.machine_status[`SBRD_MSR_BIP] = 1'b1;
        end
        if (rtb) begin
            next_st.machine_status[`SBRD_MSR_BIP] = 1'b0;
        end
        if (rti) begin
            next_st.machine_status[`SBRD_MSR_IE] = 1'b1;
        end
        next_st.machine_status[`SBRD_MSR_CC] =
            next_st.machine_status[`SBRD_MSR_CARRY];
        if (link || is_logic || is_mfs) begin
            next_st.wb.valid = 1'b1;
            next_st.wb.idx = fa;
            if (link) begin
                next_st.wb.data = ex.pc;
            end else if (is_logic) begin
                next_st.wb.data = logic_res;
            end else if (ex.word[0] == `SBRD_STATUS_SPECIAL_INDEX) begin
                next_st.wb.data = st.machine_status;
            end else begin
                next_st.wb.data = ex.pc;
            end
            next_st.gpr[fa] = next_st.wb.data;
        end
        next_st.gpr[0] = 32'h00000000;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.program_counter <= `SBRD_PC_RESET;
            st.machine_status <= `SBRD_MSR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign pc_out = st.program_counter;
    assign status_out = st.machine_status;
    assign kill_fetch = st.kill_fetch;
    assign kill_decode = st.kill_decode;
    assign wb = st.wb;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_zero_reg_held: assert property (st.gpr[0] == 32'h00000000)
        else $error("register zero is not zero");
    a_carry_copy_bit: assert property (
        status_out[`SBRD_MSR_CC] == status_out[`SBRD_MSR_CARRY])
        else $error("carry copy differs from carry");
    a_status_write_delay: assert property (
        is_mts |=> st.pend_valid ##1
        (st.machine_status[`SBRD_MSR_CARRY] ==
         $past(ra_val[`SBRD_MSR_CARRY], 2)))
        else $error("status write not applied one cycle later");
    a_break_sets_bip: assert property (
        brk |=> status_out[`SBRD_MSR_BIP] && kill_decode)
        else $error("break did not set break flag");
    a_break_ret_clear: assert property (
        rtb |=> !status_out[`SBRD_MSR_BIP] && kill_fetch && !kill_decode)
        else $error("break return did not clear flag");
    a_int_ret_ie: assert property (rti |=> status_out[`SBRD_MSR_IE])
        else $error("interrupt return did not set enable");
    a_delay_slot_kept: assert property (
        (take && delayed) |=> kill_fetch && !kill_decode)
        else $error("delayed branch flushed decode");
    a_branch_target: assert property (
        take |=> pc_out == $past(target) ##1
        ($past(take) || pc_out == $past(target, 2) + `SBRD_PC_STEP))
        else $error("program counter did not follow branch");
    a_link_writes_pc: assert property (
        (link && fa != 5'h00) |=> wb.valid && wb.data == $past(ex.pc) &&
        st.gpr[wb.idx] == $past(ex.pc))
        else $error("link did not save current address");
    a_sign_extend: assert property (
        (ex.valid && !st.pfx_valid) |-> simm[31:16] == {16{simm[15]}})
        else $error("immediate not sign-extended");
endmodule

// *** pkg/sbrd_cfg.svh ***
// Opcodes, selectors, status bit positions and reset values of the core.
`ifndef SBRD_CFG_SVH
`define SBRD_CFG_SVH
`define SBRD_OP_BCC_REG 6'h27
`define SBRD_OP_BCC_IMM 6'h2f
`define SBRD_OP_JUMP_IMM 6'h2e
`define SBRD_OP_RETURN 6'h2d
`define SBRD_OP_IMM_PREFIX 6'h2c
`define SBRD_OP_OR_IMM 6'h28
`define SBRD_OP_AND_IMM 6'h29
`define SBRD_OP_XOR_IMM 6'h2a
`define SBRD_OP_ANDN_IMM 6'h2b
`define SBRD_OP_SPECIAL 6'h25
`define SBRD_SEL_REL_DELAYED 5'h10
`define SBRD_SEL_REL_LINK 5'h14
`define SBRD_SEL_ABS 5'h08
`define SBRD_SEL_ABS_DELAYED 5'h18
`define SBRD_SEL_ABS_LINK 5'h1c
`define SBRD_SEL_BREAK 5'h0c
`define SBRD_SEL_RET_SUB 5'h10
`define SBRD_SEL_RET_INT 5'h11
`define SBRD_SEL_RET_BRK 5'h12
`define SBRD_COND_LAST 3'h5
`define SBRD_SPC_MTS 2'h3
`define SBRD_SPC_MFS 2'h2
`define SBRD_PC_SPECIAL_INDEX 1'h0
`define SBRD_STATUS_SPECIAL_INDEX 1'h1
`define SBRD_MSR_CC 31
`define SBRD_MSR_BIP 3
`define SBRD_MSR_CARRY 2
`define SBRD_MSR_IE 1
`define SBRD_MSR_RESET 32'h00000000
`define SBRD_PC_RESET 32'h00000000
`define SBRD_PC_STEP 32'h00000004
`endif

// *** pkg/sbrd_pkg.sv ***
// Types shared by the branch and return decode core.
package sbrd_pkg;
    typedef struct packed {
        logic valid;
        logic [31:0] pc;
        logic [31:0] word;
    } sbrd_exec_t;

    typedef struct packed {
        logic valid;
        logic [4:0] idx;
        logic [31:0] data;
    } sbrd_wb_t;

    typedef struct packed {
        logic [31:0][31:0] gpr;
        logic [31:0] program_counter;
        logic [31:0] machine_status;
        logic pend_valid;
        logic [31:0] pend_data;
        logic pfx_valid;
        logic [15:0] pfx_hi;
        logic kill_fetch;
        logic kill_decode;
        sbrd_wb_t wb;
    } sbrd_state_t;
endpackage

// *** tb/testbench.sv ***
// Self-checking bench for the branch and return decode core.
`timescale 1ns/1ps
`include "sbrd_cfg.svh"
module testbench;
import sbrd_pkg::*;
logic mclk;
logic rst;
sbrd_exec_t ex;
sbrd_exec_t cur;
logic [31:0] pc_out;
logic [31:0] status_out;
logic kill_fetch;
logic kill_decode;
sbrd_wb_t wb;
logic [31:0] seed = 32'h86dc78bb;
logic [31:0] rf [32];
logic [4:0] jsel [6] = '{5'h10, 5'h14, 5'h08, 5'h18, 5'h1c, 5'h0c};
logic [31:0] m_pc, m_st, pend_d, wd;
logic [15:0] pfx_hi;
logic pend_v, pfx_v, kf, kd, wv;
logic [4:0] wi;
int errors;
int compares;

sbrd_core uut (
    .mclk(mclk),
    .rst(rst),
    .ex(ex),
    .pc_out(pc_out),
    .status_out(status_out),
    .kill_fetch(kill_fetch),
    .kill_decode(kill_decode),
    .wb(wb)
);

// ----------------------------------------
// Reference model
// ----------------------------------------
function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction

function automatic logic hit(input logic [2:0] c, input logic [31:0] x);
    case (c)
        3'h0: return x == 0;
        3'h1: return x != 0;
        3'h2: return x[31];
        3'h3: return x[31] || x == 0;
        3'h4: return !x[31] && x != 0;
        default: return !x[31];
    endcase
endfunction

// Mirrors one executed word; the model state is what the outputs must show
// after the edge that executes it.
task automatic step(input logic [31:0] w, input logic [31:0] p);
    logic [4:0] a, b;
    logic [31:0] ra, imm, tgt, res, st;
    logic tk, dl;
    a = w[25:21];
    b = w[20:16];
    ra = rf[b];
    imm = pfx_v ? {pfx_hi, w[15:0]} : {{16{w[15]}}, w[15:0]};
    st = pend_v ? pend_d : m_st;
    pend_v = 0;
    tk = 0;
    dl = 1;
    wv = 0;
    res = p;
    tgt = p + imm;
    case (w[31:26])
        `SBRD_OP_BCC_REG, `SBRD_OP_BCC_IMM: begin
            if (!a[3] && a[2:0] <= 3'h5) tk = hit(a[2:0], ra);
            dl = a[4];
            if (!w[29]) tgt = p + rf[w[15:11]];
        end
        `SBRD_OP_JUMP_IMM: begin
            tk = b inside {5'h10, 5'h14, 5'h08, 5'h18, 5'h1c, 5'h0c};
            dl = b[4];
            if (b[3]) tgt = imm;
            wv = tk && b[2];
            if (b == 5'h0c) st[`SBRD_MSR_BIP] = 1'b1;
        end
        `SBRD_OP_RETURN: begin
            tk = a inside {5'h10, 5'h11, 5'h12};
            tgt = ra + imm;
            if (a == 5'h11) st[`SBRD_MSR_IE] = 1'b1;
            if (a == 5'h12) st[`SBRD_MSR_BIP] = 1'b0;
        end
        `SBRD_OP_OR_IMM, `SBRD_OP_AND_IMM, `SBRD_OP_XOR_IMM,
        `SBRD_OP_ANDN_IMM: begin
            wv = 1;
            case (w[27:26])
                2'h0: res = ra | imm;
                2'h1: res = ra & imm;
                2'h2: res = ra ^ imm;
                default: res = ra & ~imm;
            endcase
        end
        `SBRD_OP_SPECIAL: begin
            if (w[15:14] == `SBRD_SPC_MTS && w[0]) begin
                pend_v = 1;
                pend_d = {ra[2], ra[30:0]};
            end
            wv = w[15:14] == `SBRD_SPC_MFS;
            res = w[0] ? m_st : p;
        end
        default: ;
    endcase
    pfx_v = w[31:26] == `SBRD_OP_IMM_PREFIX;
    pfx_hi = w[15:0];
    wi = a;
    wd = res;
    if (wv && a != 0) rf[a] = res;
    m_st = st;
    m_pc = tk ? tgt : m_pc + `SBRD_PC_STEP;
    kf = tk;
    kd = tk && !dl;
endtask

// Every decoded group is drawn with its full selector set; the last group
// keeps off decoded opcodes so that unknown words are exercised too.
function automatic sbrd_exec_t gen();
    logic [31:0] w, r;
    w = xs();
    r = xs();
    case (r[2:0])
        3'h0, 3'h1: begin
            w[31:26] = r[0] ? `SBRD_OP_BCC_IMM : `SBRD_OP_BCC_REG;
            w[25:21] = {r[3], 1'b0, r[7:5] % 3'h6};
        end
        3'h2: begin
            w[31:26] = `SBRD_OP_JUMP_IMM;
            w[20:16] = jsel[r[5:3] % 3'h6];
        end
        3'h3: begin
            w[31:26] = `SBRD_OP_RETURN;
            w[25:21] = 5'h10 + 5'(r[4:3] % 2'h3);
        end
        3'h4: w[31:26] = {4'ha, r[4:3]};
        3'h5: begin
            w[31:26] = `SBRD_OP_IMM_PREFIX;
            w[25:16] = '0;
        end
        3'h6: begin
            w[31:26] = `SBRD_OP_SPECIAL;
            w[15:14] = {1'b1, r[3]};
            w[0] = w[0] | r[4];
        end
        default: if (w[31:26] inside {[6'h25:6'h2f]}) w[31] = ~w[31];
    endcase
    return '{valid: 1'b1, pc: m_pc, word: w};
endfunction

// ----------------------------------------
// Checking and verdict
// ----------------------------------------
task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
        errors++;
        $display("BAD %0t seen %h want %h", $time, seen, want);
    end
endtask

task automatic compare_all();
    check(pc_out, m_pc);
    check(status_out, m_st);
    check({30'h0, kill_fetch, kill_decode}, {30'h0, kf, kd});
    check({31'h0, wb.valid}, {31'h0, wv});
    if (wv) check({27'h0, wb.idx}, {27'h0, wi});
    if (wv) check(wb.data, wd);
endtask

task automatic final_report();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask

initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
end

initial begin
    rst = 1;
    ex = '0;
    errors = 0;
    compares = 0;
    m_pc = 0;
    m_st = 0;
    pend_v = 0;
    pend_d = 0;
    pfx_v = 0;
    pfx_hi = 0;
    kf = 0;
    kd = 0;
    wv = 0;
    wi = 0;
    wd = 0;
    foreach (rf[i]) rf[i] = '0;
    repeat (3) @(posedge mclk);
    #1;
    compare_all();
    @(posedge mclk);
    rst <= 0;
    cur = gen();
    ex <= cur;
    for (int n = 0; n < 3000; n++) begin
        @(posedge mclk);
        step(cur.word, cur.pc);
        cur = gen();
        ex <= cur;
        #1;
        compare_all();
    end
    final_report();
end
endmodule
